// *** hw/spi_port_map.vh ***
// Register offsets, field positions and reset values of the serial port
`ifndef SPI_PORT_MAP_VH
`define SPI_PORT_MAP_VH
`define OFS_CONTROL 12'h000
`define OFS_STATUS 12'h004
`define OFS_DATA 12'h008
`define OFS_BRG 12'h00c
`define CTL_RATE2 7
`define CTL_ENABLE 6
`define CTL_SELECT_PIN_DISABLE 5
`define CTL_MASTER 4
`define CTL_CLOCK_POLARITY_BIT 3
`define CTL_CLOCK_PHASE_BIT 2
`define CTL_RATE1 1
`define CTL_RATE0 0
`define STA_DONE 7
`define STA_WRITE_COLLISION_FLAG 6
`define STA_MODE_FAULT_FLAG 4
`define CONTROL_RESET 8'h00
`define BRG_RESET 8'h00
`define BYTE_BITS 4'h8
`endif

// *** hw/spi_master_slave_port.v ***
// Serial peripheral port, master or slave, with APB register access
`timescale 1ns/10ps
`include "spi_port_map.vh"
module spi_master_slave_port (
	input wire i_sys_clk,
	input wire i_resetn,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output reg [31:0] o_prdata,
	output reg o_pready,
	output reg o_pslverr,
	input wire i_brg_tick,
	input wire i_sck,
	output reg o_sck,
	output reg o_sck_oen,
	input wire i_mosi,
	output reg o_mosi,
	output reg o_mosi_oen,
	input wire i_miso,
	output reg o_miso,
	output reg o_miso_oen,
	input wire i_ss_n,
	output reg o_mode_fault_irq
);
	reg [7:0] serial_control_reg_q;
	reg [7:0] rx_data_q;
	reg [7:0] tx_data_q;
	reg [7:0] shift_q;
	reg transfer_complete_flag_q;
	reg write_collision_flag_q;
	reg mode_fault_flag_q;
	reg done_armed_q;
	reg write_collision_flag_armed_q;
	reg mode_fault_flag_armed_q;
	reg busy_q;
	reg tx_pending_q;
	reg [3:0] bit_cnt_q;
	reg sck_q;
	reg half_q;
	reg [6:0] div_q;
	reg [2:0] sck_s_q;
	reg [2:0] mosi_s_q;
	reg [2:0] miso_s_q;
	reg [2:0] ss_s_q;
	reg sck_f_q;
	reg mosi_f_q;
	reg miso_f_q;
	reg ss_f_q;
	wire en = serial_control_reg_q[`CTL_ENABLE];
	wire master = serial_control_reg_q[`CTL_MASTER];
	wire clock_polarity_bit = serial_control_reg_q[`CTL_CLOCK_POLARITY_BIT];
	wire clock_phase_bit = serial_control_reg_q[`CTL_CLOCK_PHASE_BIT];
	wire select_pin_disable = serial_control_reg_q[`CTL_SELECT_PIN_DISABLE];
	wire [2:0] rate = {serial_control_reg_q[`CTL_RATE2], serial_control_reg_q[`CTL_RATE1],
		serial_control_reg_q[`CTL_RATE0]};
	wire acc = i_psel && i_penable && o_pready;
	wire wr = acc && i_pwrite;
	wire rd = acc && !i_pwrite;
	wire wr_ctl = wr && (i_paddr == `OFS_CONTROL);
	wire wr_dat = wr && (i_paddr == `OFS_DATA);
	wire rd_sta = rd && (i_paddr == `OFS_STATUS);
	wire rd_dat = rd && (i_paddr == `OFS_DATA);
	wire acc_dat = acc && (i_paddr == `OFS_DATA);
	// Filtered inputs: a change counts once stages two and three agree
	always @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			sck_s_q <= 3'h0;
			mosi_s_q <= 3'h0;
			miso_s_q <= 3'h0;
			ss_s_q <= 3'h7;
			sck_f_q <= 1'b0;
			mosi_f_q <= 1'b0;
			miso_f_q <= 1'b0;
			ss_f_q <= 1'b1;
		end else begin
			sck_s_q <= {sck_s_q[1:0], i_sck};
			mosi_s_q <= {mosi_s_q[1:0], i_mosi};
			miso_s_q <= {miso_s_q[1:0], i_miso};
			ss_s_q <= {ss_s_q[1:0], i_ss_n};
			if (sck_s_q[1] == sck_s_q[2])
				sck_f_q <= sck_s_q[2];
			if (mosi_s_q[1] == mosi_s_q[2])
				mosi_f_q <= mosi_s_q[2];
			if (miso_s_q[1] == miso_s_q[2])
				miso_f_q <= miso_s_q[2];
			if (ss_s_q[1] == ss_s_q[2])
				ss_f_q <= ss_s_q[2];
		end
	end
	reg sck_prev_q;
	reg ss_prev_q;
	wire slave_sel = !ss_f_q || (clock_phase_bit && select_pin_disable);
	wire slave_on = en && !master && slave_sel;
	wire s_edge = sck_f_q != sck_prev_q;
	// Edge leaving idle samples at phase 0, returning edge at phase 1
	wire s_lead = s_edge && (sck_f_q != clock_polarity_bit);
	wire s_samp = s_edge && ((sck_f_q != clock_polarity_bit) ^ clock_phase_bit);
	wire s_shift = s_edge && !((sck_f_q != clock_polarity_bit) ^ clock_phase_bit);
	// Mode fault: SS low while master unless select pin disabled
	wire mode_fault_flag_evt = en && master && !select_pin_disable && !ss_f_q;
	// Edge detectors start at the idle levels
	always @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			sck_prev_q <= 1'b0;
			ss_prev_q <= 1'b1;
		end else begin
			sck_prev_q <= sck_f_q;
			ss_prev_q <= ss_f_q;
		end
	end
	// Half period in system clocks less one, per rate code
	reg [6:0] div_top;
	always @* begin
		case (rate)
			3'h0: div_top = 7'h00;
			3'h1: div_top = 7'h01;
			3'h2: div_top = 7'h03;
			3'h3: div_top = 7'h07;
			3'h4: div_top = 7'h0f;
			3'h5: div_top = 7'h1f;
			3'h6: div_top = 7'h3f;
			default: div_top = 7'h00;
		endcase
	end
	// Code 7 hands the stepping over to the external generator
	wire use_brg = (rate == 3'h7);
	wire div_end = (div_q == div_top);
	wire m_step = busy_q && master && (use_brg ? i_brg_tick : div_end);
	// Divider restarts with each transfer so the first half period is full
	always @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			div_q <= 7'h00;
		end else if (busy_q && master && !use_brg && !div_end) begin
			div_q <= div_q + 7'h01;
		end else begin
			div_q <= 7'h00;
		end
	end
	// Transfer start paths
	wire m_load = wr_dat && !busy_q && en && master;
	wire m_reload = !mode_fault_flag_evt && tx_pending_q && en && master && !busy_q && !wr_dat;
	wire [7:0] status_word = {transfer_complete_flag_q, write_collision_flag_q, 1'b0,
		mode_fault_flag_q, busy_q, 3'h0};
	wire setup_phase = i_psel && !o_pready;
	wire adr_misaligned = (i_paddr[1:0] != 2'h0);
	wire adr_beyond = (i_paddr > `OFS_BRG);
	reg [31:0] read_word;
	always @* begin
		read_word = 32'h0;
		case (i_paddr)
			`OFS_CONTROL: read_word = {24'h0, serial_control_reg_q};
			`OFS_STATUS: read_word = {24'h0, status_word};
			`OFS_DATA: read_word = {24'h0, rx_data_q};
			default: read_word = 32'h0;
		endcase
	end
	always @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			serial_control_reg_q <= `CONTROL_RESET;
			rx_data_q <= 8'h00;
			tx_data_q <= 8'h00;
			shift_q <= 8'h00;
			transfer_complete_flag_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
			mode_fault_flag_q <= 1'b0;
			done_armed_q <= 1'b0;
			write_collision_flag_armed_q <= 1'b0;
			mode_fault_flag_armed_q <= 1'b0;
			busy_q <= 1'b0;
			tx_pending_q <= 1'b0;
			bit_cnt_q <= 4'h0;
			sck_q <= 1'b0;
			half_q <= 1'b0;
		end else begin
			// Flag clears first, so a same-cycle set below wins
			if (rd_sta)
				done_armed_q <= transfer_complete_flag_q;
			if (rd_dat && done_armed_q) begin
				transfer_complete_flag_q <= 1'b0;
				done_armed_q <= 1'b0;
			end
			if (rd_sta)
				write_collision_flag_armed_q <= write_collision_flag_q;
			if (acc_dat && !rd_sta && write_collision_flag_armed_q) begin
				write_collision_flag_q <= 1'b0;
				write_collision_flag_armed_q <= 1'b0;
			end
			if (rd_sta)
				mode_fault_flag_armed_q <= mode_fault_flag_q;
			if (wr_ctl) begin
				serial_control_reg_q <= i_pwdata[7:0];
				if (mode_fault_flag_armed_q) begin
					mode_fault_flag_q <= 1'b0;
					mode_fault_flag_armed_q <= 1'b0;
				end
			end
			if (!busy_q)
				sck_q <= clock_polarity_bit;
			if (wr_dat) begin
				tx_data_q <= i_pwdata[7:0];
				if (busy_q)
					write_collision_flag_q <= 1'b1;
				else if (en && master) begin
					shift_q <= i_pwdata[7:0];
					busy_q <= 1'b1;
					bit_cnt_q <= 4'h0;
					half_q <= 1'b0;
					tx_pending_q <= 1'b0;
				end else begin
					shift_q <= i_pwdata[7:0];
				end
			end
			if (mode_fault_flag_evt) begin
				mode_fault_flag_q <= 1'b1;
				serial_control_reg_q[`CTL_ENABLE] <= 1'b0;
				serial_control_reg_q[`CTL_MASTER] <= 1'b0;
				if (busy_q && master) begin
					busy_q <= 1'b0;
					tx_pending_q <= 1'b1;
					sck_q <= clock_polarity_bit;
				end
			end else if (m_reload) begin
				shift_q <= tx_data_q;
				busy_q <= 1'b1;
				bit_cnt_q <= 4'h0;
				half_q <= 1'b0;
				tx_pending_q <= 1'b0;
			end else if (m_step) begin
				sck_q <= ~sck_q;
				half_q <= ~half_q;
				// Capture on the first half at phase 0, second at phase 1
				if (half_q == clock_phase_bit)
					shift_q <= {shift_q[6:0], miso_f_q};
				if (half_q) begin
					bit_cnt_q <= bit_cnt_q + 4'h1;
					if (bit_cnt_q == `BYTE_BITS - 4'h1) begin
						busy_q <= 1'b0;
						transfer_complete_flag_q <= 1'b1;
						rx_data_q <= clock_phase_bit ? {shift_q[6:0], miso_f_q} : shift_q;
					end
				end
			end
			if (slave_on && !master) begin
				if (!ss_f_q && ss_prev_q && !clock_phase_bit)
					bit_cnt_q <= 4'h0;
				if (s_samp) begin
					shift_q <= {shift_q[6:0], mosi_f_q};
					bit_cnt_q <= bit_cnt_q + 4'h1;
					if (bit_cnt_q == `BYTE_BITS - 4'h1) begin
						rx_data_q <= {shift_q[6:0], mosi_f_q};
						transfer_complete_flag_q <= 1'b1;
						bit_cnt_q <= 4'h0;
					end
				end
			end
		end
	end
	// Phase 0 presents the MSB before the first edge; sampled byte rides shift_q
	reg [7:0] out_byte_q;
	always @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			out_byte_q <= 8'h00;
			o_mosi <= 1'b0;
			o_miso <= 1'b0;
			o_sck <= 1'b0;
			o_sck_oen <= 1'b1;
			o_mosi_oen <= 1'b1;
			o_miso_oen <= 1'b1;
			o_mode_fault_irq <= 1'b0;
			o_prdata <= 32'h0;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			// Start paths load the byte itself, the shifter is written in the same cycle
			if (m_load)
				out_byte_q <= i_pwdata[7:0];
			else if (m_reload)
				out_byte_q <= tx_data_q;
			else if (!busy_q && !slave_on)
				out_byte_q <= shift_q;
			// Master moves MOSI on the edge opposite to sampling
			else if (master ? (m_step && half_q != clock_phase_bit && !(clock_phase_bit && bit_cnt_q == 4'h0))
				: (s_shift && !(s_lead && !clock_phase_bit)))
				out_byte_q <= {out_byte_q[6:0], 1'b0};
			else if (!master && s_lead && clock_phase_bit && bit_cnt_q == 4'h0)
				out_byte_q <= shift_q;
			o_mosi <= out_byte_q[7];
			o_miso <= out_byte_q[7];
			o_sck <= sck_q;
			o_sck_oen <= !(en && master);
			o_mosi_oen <= !(en && master);
			o_miso_oen <= !slave_on;
			o_mode_fault_irq <= mode_fault_flag_q && !select_pin_disable;
			// No wait state: pready rises in the first access cycle, drops after
			o_pready <= setup_phase;
			o_pslverr <= setup_phase && (adr_misaligned || adr_beyond);
			o_prdata <= read_word;
		end
	end
endmodule

// *** test/spi_port_asserts.sv ***
// Port checker for the serial port, bound to its top module
`timescale 1ns/10ps
module spi_port_asserts (
	input wire i_sys_clk,
	input wire i_resetn,
	input wire i_psel,
	input wire i_penable,
	input wire o_pready,
	input wire o_pslverr,
	input wire o_sck_oen,
	input wire o_mosi_oen,
	input wire o_miso_oen,
	input wire i_ss_n,
	input wire o_mode_fault_irq
);
default clocking @(posedge i_sys_clk); endclocking
default disable iff (!i_resetn);
a_reset_quiet: assert property ($rose(i_resetn) |-> o_sck_oen && o_mosi_oen && o_miso_oen)
	else $error("pins driven after reset");
a_ready_wait: assert property (i_psel && !i_penable |=> o_pready)
	else $error("no ready after setup");
a_ready_pulse: assert property (o_pready |=> !o_pready)
	else $error("ready held two cycles");
a_ready_access: assert property (o_pready |-> i_psel && i_penable)
	else $error("ready outside access");
a_err_ready: assert property (o_pslverr |-> o_pready)
	else $error("error without ready");
a_miso_float: assert property (i_ss_n [*8] |-> o_miso_oen)
	else $error("miso driven while unselected");
a_one_driver: assert property (!o_sck_oen |-> o_miso_oen)
	else $error("master also drives miso");
a_master_pins: assert property (!o_mosi_oen |-> !o_sck_oen)
	else $error("mosi driven without clock");
a_fault_stop: assert property ($rose(o_mode_fault_irq) |-> ##[0:3] o_sck_oen)
	else $error("master kept clock after fault");
endmodule
bind spi_master_slave_port spi_port_asserts u_chk (.i_sys_clk, .i_resetn, .i_psel,
	.i_penable, .o_pready, .o_pslverr, .o_sck_oen, .o_mosi_oen, .o_miso_oen, .i_ss_n,
	.o_mode_fault_irq);

// *** test/spi_peer.sv ***
// Behavioural slave peer on the far side of the master port
`timescale 1ns/10ps
module spi_peer (
	input wire logic i_sck,
	input wire logic i_mosi,
	input wire logic i_sel_n,
	input wire logic [7:0] i_tx,
	output logic o_miso,
	output logic [7:0] o_rx,
	output int o_edges
);
logic [7:0] sh_q;
initial o_miso = 1'b0;
always @(negedge i_sel_n) begin
	sh_q = i_tx;
	o_miso = i_tx[7];
	o_edges = 0;
end
always @(posedge i_sck) if (!i_sel_n) begin
	o_rx = {o_rx[6:0], i_mosi};
	o_edges++;
end
always @(negedge i_sck) if (!i_sel_n) begin
	sh_q = sh_q << 1;
	o_miso = sh_q[7];
end
// Released line shows the inverse, never a stale bit
always @(posedge i_sel_n) o_miso = ~o_miso;
endmodule

// *** test/spi_master_slave_port_tb_top.sv ***
// Bench for the serial port: registers, master and slave traffic
`timescale 1ns/10ps
module spi_master_slave_port_tb_top;
logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, brg = 0;
logic sck = 0, mosi = 0, ssn = 1, sel_n = 1;
logic [11:0] adr = 0;
logic [31:0] wd = 0, q;
logic [7:0] r;
wire [31:0] rd;
wire [7:0] prx;
wire rdy, osck, soen, omosi, omiso, irq, pmiso;
int pedges, fail_count = 0, tests_run = 0, hi = 0;
initial forever #4 clk = ~clk;
always @(posedge clk) brg <= ~brg;
always @(posedge clk) if (!soen && osck) hi++;
spi_master_slave_port u_dut (.i_sys_clk(clk), .i_resetn(rstn), .i_psel(psel),
	.i_penable(pen), .i_pwrite(pwr), .i_paddr(adr), .i_pwdata(wd), .o_prdata(rd),
	.o_pready(rdy), .o_pslverr(), .i_brg_tick(brg), .i_sck(sck), .o_sck(osck),
	.o_sck_oen(soen), .i_mosi(mosi), .o_mosi(omosi), .o_mosi_oen(), .i_miso(pmiso),
	.o_miso(omiso), .o_miso_oen(), .i_ss_n(ssn), .o_mode_fault_irq(irq));
spi_peer u_peer (.i_sck(soen ? 1'b0 : osck), .i_mosi(omosi), .i_sel_n(sel_n),
	.i_tx(8'h3c), .o_miso(pmiso), .o_rx(prx), .o_edges(pedges));
task stop_test;
	if (fail_count == 0 && tests_run > 0)
		$display("No errors found");
	else
		$display("Errors were found");
	$finish;
endtask
task chk(input string n, input logic [31:0] e, input logic [31:0] g);
	tests_run++;
	if (g !== e) begin
		fail_count++;
		$display("CHECK FAILED %s expected %h seen %h", n, e, g);
	end
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
	@(posedge clk);
	psel <= 1;
	pwr <= w;
	adr <= a;
	wd <= d;
	@(posedge clk);
	pen <= 1;
	@(posedge clk);
	while (rdy !== 1'b1) @(posedge clk);
	q = rd;
	psel <= 0;
	pen <= 0;
endtask
task wait_done;
	repeat (200) begin
		apb(0, 12'h004, 0);
		if (q[7] === 1'b1) break;
	end
endtask
task t_master;
	apb(1, 12'h000, 32'h73);
	sel_n <= 0;
	apb(1, 12'h008, 32'ha5);
	apb(1, 12'h008, 32'h11);
	wait_done;
	chk("write_collision_flag", 1, q[6]);
	apb(0, 12'h008, 0);
	chk("master rx", 32'h3c, q);
	chk("peer rx", 8'ha5, prx);
	chk("sck edges", 8, pedges);
	apb(0, 12'h004, 0);
	chk("flags clear", 0, q[7:6]);
	sel_n <= 1;
endtask
task t_rates;
	for (int n = 0; n < 5; n++) begin
		apb(1, 12'h000, n == 4 ? 32'hf3 : 32'h70 | n);
		#1 hi = 0;
		apb(1, 12'h008, 0);
		wait_done;
		apb(0, 12'h008, 0);
		// Tick every other cycle doubles each half period
		chk("sck high", n == 4 ? 16 : 8 << n, hi);
	end
endtask
task t_slave(input logic [7:0] b);
	apb(1, 12'h000, 32'h40);
	apb(1, 12'h008, 32'h96);
	ssn <= 0;
	mosi <= b[7];
	repeat (12) @(posedge clk);
	for (int i = 7; i >= 0; i--) begin
		r[i] = omiso;
		sck <= 1;
		repeat (12) @(posedge clk);
		sck <= 0;
		mosi <= i ? b[i - 1] : 1'b0;
		repeat (12) @(posedge clk);
	end
	ssn <= 1;
	chk("slave tx", 8'h96, r);
	wait_done;
	apb(0, 12'h008, 0);
	chk("slave rx", {24'h0, b}, q);
endtask
task t_fault;
	apb(1, 12'h000, 32'h73);
	ssn <= 0;
	repeat (10) @(posedge clk);
	apb(0, 12'h004, 0);
	chk("no mode_fault_flag", 0, q[4]);
	apb(1, 12'h000, 32'h53);
	repeat (10) @(posedge clk);
	chk("irq", 1, irq);
	apb(0, 12'h000, 0);
	chk("en master", 0, {q[6], q[4]});
	apb(0, 12'h004, 0);
	chk("mode_fault_flag", 1, q[4]);
	apb(1, 12'h000, 0);
	repeat (2) @(posedge clk);
	chk("irq clear", 0, irq);
	ssn <= 1;
endtask
initial begin
	#200000;
	fail_count++;
	stop_test;
end
initial begin
	repeat (8) @(posedge clk);
	rstn <= 1;
	apb(0, 12'h000, 0);
	chk("ctl reset", 0, q);
	apb(0, 12'h004, 0);
	chk("sta reset", 0, q);
	t_master;
	t_rates;
	t_slave(8'h5a);
	t_fault;
	stop_test;
end
endmodule
